//--- hw/scs_frame_if.sv
`timescale 1ns/1ps
interface scs_frame_if;
   logic frame_valid;
   logic [15:0] frame;
   logic [15:0] rd_data;
   logic busy;
   modport serial (output frame_valid, output frame,
                   input rd_data, input busy);
   modport regs (input frame_valid, input frame,
                 output rd_data, output busy);
endinterface

//--- hw/scs_pkg.sv
package scs_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned INT_RATE_HZ = 2000;
   localparam int unsigned INT_PERIOD_CYC = CLK_HZ / INT_RATE_HZ;
   localparam int unsigned PULSE_NS = 1000;
   localparam int unsigned PULSE_CYC = PULSE_NS * (CLK_HZ / 1_000_000)
                                       / 1000;
   localparam int unsigned CMD_TIME_US = 1000;
   localparam int unsigned CMD_CYC = CMD_TIME_US * (CLK_HZ / 1_000_000);

   // ---------------------------------------------------------------
   // Register byte offsets on the serial port
   // ---------------------------------------------------------------
   localparam logic [6:0] MISC_OFS = 7'h60;
   localparam logic [6:0] MULT_OFS = 7'h62;
   localparam logic [6:0] DEC_OFS = 7'h64;
   localparam logic [6:0] NULL_OFS = 7'h66;
   localparam logic [6:0] GCMD_OFS = 7'h68;

   // ---------------------------------------------------------------
   // Fields and reset values
   // ---------------------------------------------------------------
   localparam int unsigned MISC_LING_BIT = 7;
   localparam int unsigned MISC_POC_BIT = 6;
   localparam int unsigned MISC_MODE_LSB = 2;
   localparam int unsigned MISC_SPOL_BIT = 1;
   localparam int unsigned MISC_DRPOL_BIT = 0;
   localparam logic [7:0] MISC_RST = 8'hc1;
   localparam logic [15:0] MULT_RST = 16'h07d0;
   localparam logic [10:0] DEC_RST = 11'h000;
   localparam logic [10:0] DEC_MAX = 11'h7cf;
   localparam logic [15:0] NULL_RST = 16'h070a;
   localparam int unsigned NULL_EN_LSB = 8;
   localparam logic [3:0] EXP_MAX = 4'hc;
   localparam int unsigned BIAS_AVG_SHIFT = 6;
   localparam int unsigned GCMD_BIAS_BIT = 0;

   typedef enum logic [2:0] {
      MODE_INTERNAL = 3'b000,
      MODE_DIRECT = 3'b001,
      MODE_SCALED = 3'b010,
      MODE_OUTPUT = 3'b011,
      MODE_PULSE = 3'b101
   } sync_mode_t;

endpackage

//--- hw/scs_sample_clock.sv
// How it works
// R1 - Gyro linear-g compensation follows control bit 7, on at reset.
// R2 - Host clears compensation with frames 0xE041 then 0xE100.
// R3 - Mode field 000 at reset: internal 2000 Hz sample pacing.
// R4 - Internal mode averages two accelerometer samples taken at 4000 Hz.
// R5 - Mode 001: gyro on active trigger edge, accelerometer on both edges.
// R6 - Direct mode averages the two accelerometer samples per period.
// R7 - Host drives a 50% duty trigger at 1900 to 2100 Hz.
// R8 - Mode 010 is scaled trigger mode; trigger runs 1 to 128 Hz.
// R9 - Scaled mode sample rate equals trigger rate times the multiplier.
// R10 - Host loads multiplier low byte first, then high byte.
// R11 - Mode 011 paces internally and pulses the trigger pin each sample.
// R12 - Mode 101 samples accelerometers on the leading trigger edge only.
// R13 - Pulse mode flags the reduced 370 Hz sensor bandwidth.
// R14 - Host should keep pulse-mode trigger between 1000 and 2100 Hz.
// R15 - Decimation count is bits 10..0, maximum 1999, upper bits ignored.
// R16 - Gyro and accel data accumulate over each decimated update.
// R17 - Internal mode output rate is 2000 over decimation count plus one.
// R18 - Trigger modes divide their sample rate by decimation count plus one.
// R19 - Estimator config holds per-sensor enables, accel 13..11, gyro 10..8.
// R20 - Time-base exponent 0..12; average spans 64 times 2^n samples.
// R21 - Bias update command applies the estimator's current factors.
// R22 - Estimator config resets to 0x070a: gyros on, accels off.
// R23 - Control bit 1 selects the trigger edge: 1 rising, 0 falling.
// R24 - Reserved mode codes 100, 110, 111 are refused.
// R25 - Bias update command halts data, ready pulses and the port.
// R26 - A mode change restarts pacing and drops the partial update.
// R27 - Decimation writes above 1999 are clamped to 1999.
`timescale 1ns/1ps
module scs_sample_clock #(
   parameter int unsigned INT_PERIOD_CYC = scs_pkg::INT_PERIOD_CYC,
   parameter int unsigned CMD_CYC = scs_pkg::CMD_CYC
) (
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic SPI_CS_N,
   input wire logic SPI_SCLK,
   input wire logic SPI_DIN,
   output logic SPI_DOUT,
   input wire logic SYNC_IN,
   output logic SYNC_OUT,
   output logic SYNC_OE,
   output logic DATA_READY,
   input wire logic [47:0] GYRO_DATA,
   input wire logic [47:0] ACCEL_DATA,
   output logic [95:0] DELTA_ANGLE,
   output logic [95:0] DELTA_VEL,
   output logic [95:0] BIAS_CORR,
   output logic GYRO_SAMPLE,
   output logic ACCEL_SAMPLE,
   output logic GYRO_LIN_G_COMP,
   output logic POC_ENABLE,
   output logic BANDWIDTH_370,
   output logic CMD_BUSY
);
   localparam int PW = $clog2(INT_PERIOD_CYC + 1);
   localparam int CW = $clog2(CMD_CYC + 1);

   scs_frame_if fif ();

   scs_serial u_serial (
      .clk(SYS_CLK),
      .rst_n(RESETN),
      .cs_n(SPI_CS_N),
      .sclk(SPI_SCLK),
      .din(SPI_DIN),
      .dout(SPI_DOUT),
      .bus(fif.serial)
   );

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic wr_en;
   logic [6:0] wr_addr;
   logic [7:0] wr_byte;
   logic [3:0] flags_q;
   scs_pkg::sync_mode_t mode_q;
   logic [15:0] mult_q;
   logic [10:0] dec_q;
   logic [5:0] en_q;
   logic [3:0] exp_q;
   logic [6:0] rd_addr_q;
   logic mode_legal;
   logic mode_restart;
   logic bias_cmd;
   logic [CW-1:0] busy_q;
   logic busy;

   assign wr_en = fif.frame_valid & fif.frame[15];
   assign wr_addr = fif.frame[14:8];
   assign wr_byte = fif.frame[7:0];
   assign mode_legal = wr_byte[4:2] != 3'b100 && wr_byte[4:1] != 4'b1100
                       && wr_byte[4:1] != 4'b1101 && wr_byte[4:2] != 3'b111;

   function automatic logic hit(input logic [6:0] a, input logic [6:0] b);
      hit = a[6:1] == b[6:1];
   endfunction

   function automatic logic [10:0] clamp_dec(input logic [10:0] v);
      clamp_dec = (v > scs_pkg::DEC_MAX) ? scs_pkg::DEC_MAX : v; // R27
   endfunction

   assign mode_restart = wr_en && hit(wr_addr, scs_pkg::MISC_OFS)
                         && !wr_addr[0] && mode_legal
                         && wr_byte[4:2] != mode_q; // R26
   assign bias_cmd = wr_en && hit(wr_addr, scs_pkg::GCMD_OFS) && !wr_addr[0]
                     && wr_byte[scs_pkg::GCMD_BIAS_BIT]; // R21

   // Control flags kept as {lin-g, percussion, trigger edge, ready pol}
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         flags_q <= {scs_pkg::MISC_RST[7:6], scs_pkg::MISC_RST[1:0]};
         mode_q <= scs_pkg::sync_mode_t'(scs_pkg::MISC_RST[4:2]); // R3
      end else if (wr_en && hit(wr_addr, scs_pkg::MISC_OFS)
                   && !wr_addr[0]) begin
         flags_q <= {wr_byte[scs_pkg::MISC_LING_BIT],
                     wr_byte[scs_pkg::MISC_POC_BIT],
                     wr_byte[scs_pkg::MISC_SPOL_BIT],
                     wr_byte[scs_pkg::MISC_DRPOL_BIT]}; // R1 R23
         if (mode_legal) begin
            mode_q <= scs_pkg::sync_mode_t'(wr_byte[4:2]); // R24
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         mult_q <= scs_pkg::MULT_RST;
         dec_q <= scs_pkg::DEC_RST;
         en_q <= scs_pkg::NULL_RST[13:8];
         exp_q <= scs_pkg::NULL_RST[3:0]; // R22
      end else if (wr_en) begin
         if (hit(wr_addr, scs_pkg::MULT_OFS)) begin
            if (wr_addr[0]) mult_q[15:8] <= wr_byte;
            else mult_q[7:0] <= wr_byte;
         end
         if (hit(wr_addr, scs_pkg::DEC_OFS)) begin
            if (wr_addr[0]) dec_q <= clamp_dec({wr_byte[2:0], dec_q[7:0]});
            else dec_q <= clamp_dec({dec_q[10:8], wr_byte}); // R15
         end
         if (hit(wr_addr, scs_pkg::NULL_OFS)) begin
            if (wr_addr[0]) en_q <= wr_byte[5:0]; // R19
            else exp_q <= (wr_byte[3:0] > scs_pkg::EXP_MAX) ?
                          scs_pkg::EXP_MAX : wr_byte[3:0]; // R20
         end
      end
   end

   // Read frame names the word returned in the next frame
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) rd_addr_q <= 7'h00;
      else if (fif.frame_valid && !fif.frame[15]) rd_addr_q <= wr_addr;
   end

   always_comb begin
      fif.rd_data = 16'h0000;
      if (hit(rd_addr_q, scs_pkg::MISC_OFS))
         fif.rd_data = {8'h00, flags_q[3:2], 1'b0, mode_q, flags_q[1:0]};
      else if (hit(rd_addr_q, scs_pkg::MULT_OFS)) fif.rd_data = mult_q;
      else if (hit(rd_addr_q, scs_pkg::DEC_OFS)) fif.rd_data = {5'h00, dec_q};
      else if (hit(rd_addr_q, scs_pkg::NULL_OFS))
         fif.rd_data = {2'h0, en_q, 4'h0, exp_q};
   end

   // Command time: sample ticks stall, the port answers nothing
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) busy_q <= '0;
      else if (bias_cmd && !busy) busy_q <= CW'(CMD_CYC); // R25
      else if (busy) busy_q <= busy_q - CW'(1);
   end
   assign busy = busy_q != '0;
   assign fif.busy = busy;

   // ---------------------------------------------------------------
   // Sample pacing
   // ---------------------------------------------------------------
   logic trig_q;
   logic act_e;
   logic oth_e;
   logic [PW-1:0] per_q;
   logic int_full;
   logic int_half;
   logic [31:0] tcnt_q;
   logic [31:0] tper_q;
   logic [1:0] armed_q;
   logic [31:0] dds_q;
   logic [32:0] dds_sum;
   logic dds_emit;
   logic gyro_tick;
   logic accel_tick;
   logic paired;

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) trig_q <= 1'b0;
      else trig_q <= SYNC_IN;
   end
   assign act_e = flags_q[1] ? (SYNC_IN & ~trig_q)
                             : (~SYNC_IN & trig_q); // R23
   assign oth_e = flags_q[1] ? (~SYNC_IN & trig_q) : (SYNC_IN & ~trig_q);

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN || mode_restart || int_full) per_q <= '0;
      else per_q <= per_q + PW'(1);
   end
   assign int_full = per_q == PW'(INT_PERIOD_CYC - 1); // R3
   assign int_half = per_q == PW'(INT_PERIOD_CYC / 2 - 1); // R4

   // Scaled mode: phase accumulator adds the multiplier every cycle and
   // wraps on the measured trigger period, so rate = f_trig * multiplier
   assign dds_sum = {1'b0, dds_q} + 33'(mult_q);
   assign dds_emit = armed_q == 2'b11 && dds_sum >= {1'b0, tper_q}; // R9
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN || mode_restart) begin
         tcnt_q <= 32'h0000_0000;
         tper_q <= 32'h0000_0000;
         armed_q <= 2'b00;
         dds_q <= 32'h0000_0000;
      end else if (mode_q == scs_pkg::MODE_SCALED) begin
         if (act_e) begin
            tcnt_q <= 32'h0000_0001;
            armed_q <= {armed_q[0], 1'b1};
            if (armed_q[0]) tper_q <= tcnt_q;
         end else if (tcnt_q != 32'hffff_ffff) begin
            tcnt_q <= tcnt_q + 32'h0000_0001;
         end
         if (armed_q == 2'b11) begin
            dds_q <= dds_emit ? 32'(dds_sum - {1'b0, tper_q})
                              : dds_sum[31:0]; // R8
         end
      end
   end

   always_comb begin
      gyro_tick = 1'b0;
      accel_tick = 1'b0;
      paired = 1'b0;
      unique case (mode_q)
         scs_pkg::MODE_INTERNAL, scs_pkg::MODE_OUTPUT: begin
            gyro_tick = int_full; // R11
            accel_tick = int_full | int_half;
            paired = 1'b1;
         end
         scs_pkg::MODE_DIRECT: begin
            gyro_tick = act_e; // R5
            accel_tick = act_e | oth_e;
            paired = 1'b1;
         end
         scs_pkg::MODE_SCALED: begin
            gyro_tick = dds_emit;
            accel_tick = dds_emit;
         end
         scs_pkg::MODE_PULSE: begin
            gyro_tick = act_e; // R12
            accel_tick = act_e;
         end
      endcase
      if (busy || mode_restart) begin
         gyro_tick = 1'b0; // R25
         accel_tick = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Sample averaging and decimation
   // ---------------------------------------------------------------
   logic signed [15:0] smp [6];
   logic signed [15:0] half_q [3];
   logic half_ok_q;
   logic [10:0] dcnt_q;
   logic signed [31:0] sum_q [6];
   logic dr_start;

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         smp[i] = GYRO_DATA[16*i +: 16];
         smp[i+3] = ACCEL_DATA[16*i +: 16];
         if (paired && half_ok_q)
            smp[i+3] = 16'((17'(half_q[i]) + 17'(smp[i+3])) >>> 1); // R6
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN || mode_restart) begin
         half_ok_q <= 1'b0;
         for (int i = 0; i < 3; i++) half_q[i] <= 16'h0000;
      end else if (gyro_tick) begin
         half_ok_q <= 1'b0;
      end else if (accel_tick && paired) begin
         half_ok_q <= 1'b1; // R4
         for (int i = 0; i < 3; i++) half_q[i] <= ACCEL_DATA[16*i +: 16];
      end
   end

   assign dr_start = gyro_tick && dcnt_q >= dec_q; // R17 R18
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN || mode_restart) begin
         dcnt_q <= 11'h000; // R26
         for (int i = 0; i < 6; i++) sum_q[i] <= 32'h0000_0000;
      end else if (gyro_tick) begin
         dcnt_q <= dr_start ? 11'h000 : dcnt_q + 11'h001;
         for (int i = 0; i < 6; i++)
            sum_q[i] <= dr_start ? 32'h0000_0000 : sum_q[i] + 32'(smp[i]);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         DELTA_ANGLE <= '0;
         DELTA_VEL <= '0;
      end else if (dr_start) begin
         for (int i = 0; i < 3; i++) begin
            DELTA_ANGLE[32*i +: 32] <= sum_q[i] + 32'(smp[i]); // R16
            DELTA_VEL[32*i +: 32] <= sum_q[i+3] + 32'(smp[i+3]);
         end
      end
   end

   // ---------------------------------------------------------------
   // Continuous bias estimator
   // ---------------------------------------------------------------
   logic signed [34:0] bsum_q [6];
   logic signed [15:0] est_q [6];
   logic signed [15:0] corr_q [6];
   logic [18:0] bcnt_q;
   logic bwin_end;

   // Window is 64 time bases of 2^n samples each
   assign bwin_end = gyro_tick && bcnt_q >= (19'h00001 <<
                     (scs_pkg::BIAS_AVG_SHIFT + exp_q)) - 19'h00001; // R20
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         bcnt_q <= 19'h00000;
         for (int i = 0; i < 6; i++) begin
            bsum_q[i] <= 35'h0;
            est_q[i] <= 16'h0000;
         end
      end else if (gyro_tick) begin
         bcnt_q <= bwin_end ? 19'h00000 : bcnt_q + 19'h00001;
         for (int i = 0; i < 6; i++) begin
            bsum_q[i] <= bwin_end ? 35'h0 : bsum_q[i] + 35'(smp[i]);
            if (bwin_end)
               est_q[i] <= 16'((bsum_q[i] + 35'(smp[i])) >>>
                               (scs_pkg::BIAS_AVG_SHIFT + exp_q));
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         for (int i = 0; i < 6; i++) corr_q[i] <= 16'h0000;
      end else if (bias_cmd && !busy) begin
         for (int i = 0; i < 6; i++)
            if (en_q[i]) corr_q[i] <= corr_q[i] - est_q[i]; // R21 R19
      end
   end
   always_comb begin
      for (int i = 0; i < 6; i++) BIAS_CORR[16*i +: 16] = corr_q[i];
   end

   // ---------------------------------------------------------------
   // Ready and trigger-out pulses, strobes
   // ---------------------------------------------------------------
   logic [7:0] dr_q;
   logic [7:0] so_q;
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         dr_q <= 8'h00;
         so_q <= 8'h00;
         GYRO_SAMPLE <= 1'b0;
         ACCEL_SAMPLE <= 1'b0;
      end else begin
         dr_q <= dr_start ? 8'(scs_pkg::PULSE_CYC)
                          : dr_q - 8'(dr_q != 8'h00);
         so_q <= (gyro_tick && mode_q == scs_pkg::MODE_OUTPUT) ?
                 8'(scs_pkg::PULSE_CYC) : so_q - 8'(so_q != 8'h00); // R11
         GYRO_SAMPLE <= gyro_tick;
         ACCEL_SAMPLE <= accel_tick;
      end
   end
   assign DATA_READY = ~((dr_q != 8'h00) ^ flags_q[0]);
   assign SYNC_OE = mode_q == scs_pkg::MODE_OUTPUT;
   assign SYNC_OUT = SYNC_OE && ((so_q != 8'h00) == flags_q[1]);
   assign GYRO_LIN_G_COMP = flags_q[3]; // R1
   assign POC_ENABLE = flags_q[2];
   assign BANDWIDTH_370 = mode_q == scs_pkg::MODE_PULSE; // R13
   assign CMD_BUSY = busy;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [PW:0] gap_q;
   logic gap_ok_q;
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN || mode_restart || busy) begin
         gap_q <= '0;
         gap_ok_q <= 1'b0;
      end else if (gyro_tick) begin
         gap_q <= '0;
         gap_ok_q <= 1'b1;
      end else begin
         gap_q <= gap_q + (PW+1)'(1);
      end
   end

   chk_lin_g_write: assert property (@(posedge SYS_CLK) // R1
      disable iff (!RESETN)
      wr_en && wr_addr == scs_pkg::MISC_OFS |=>
      GYRO_LIN_G_COMP == $past(wr_byte[7]))
      else $error("compensation enable did not follow write");
   chk_reset_defaults: assert property (@(posedge SYS_CLK) // R3
      disable iff (!RESETN)
      $rose(RESETN) |-> mode_q == scs_pkg::MODE_INTERNAL && GYRO_LIN_G_COMP
      && dec_q == 11'h000 && mult_q == 16'h07d0)
      else $error("wrong pacing defaults after reset");
   chk_null_reset: assert property (@(posedge SYS_CLK) // R22
      disable iff (!RESETN)
      $rose(RESETN) |-> {en_q, exp_q} == 10'h07a)
      else $error("estimator config reset value wrong");
   chk_int_period: assert property (@(posedge SYS_CLK) // R3
      disable iff (!RESETN)
      gyro_tick && gap_ok_q && mode_q == scs_pkg::MODE_INTERNAL |->
      gap_q == (PW+1)'(INT_PERIOD_CYC - 1))
      else $error("internal sample period wrong");
   chk_direct_edges: assert property (@(posedge SYS_CLK) // R5
      disable iff (!RESETN)
      mode_q == scs_pkg::MODE_DIRECT && !busy && !mode_restart && oth_e
      |-> accel_tick && !gyro_tick ##1 half_ok_q)
      else $error("direct mode second edge not sampled");
   chk_pulse_edge: assert property (@(posedge SYS_CLK) // R12
      disable iff (!RESETN)
      mode_q == scs_pkg::MODE_PULSE && oth_e |-> !accel_tick)
      else $error("pulse mode sampled on trailing edge");
   chk_dec_clamp: assert property (@(posedge SYS_CLK) // R27
      disable iff (!RESETN)
      wr_en && wr_addr == scs_pkg::DEC_OFS + 7'h01 && wr_byte[2:0] == 3'b111
      && dec_q[7:0] > 8'hcf |=> dec_q == scs_pkg::DEC_MAX)
      else $error("decimation count not clamped");
   chk_dr_rate: assert property (@(posedge SYS_CLK) // R17
      disable iff (!RESETN)
      dr_start |=> dcnt_q == 11'h000 ##0 DATA_READY == flags_q[0] [*8])
      else $error("ready pulse or decimation restart wrong");
   chk_busy_quiet: assert property (@(posedge SYS_CLK) // R25
      disable iff (!RESETN)
      $rose(busy) |-> (!gyro_tick && !fif.frame_valid) [*8])
      else $error("activity during command");
   chk_sync_out: assert property (@(posedge SYS_CLK) // R11
      disable iff (!RESETN)
      gyro_tick && mode_q == scs_pkg::MODE_OUTPUT && !mode_restart |=>
      SYNC_OE && SYNC_OUT == flags_q[1])
      else $error("output-mode trigger pulse missing");
   chk_reserved_mode: assert property (@(posedge SYS_CLK) // R24
      disable iff (!RESETN)
      wr_en && wr_addr == scs_pkg::MISC_OFS && wr_byte[4:2] == 3'b100
      |=> mode_q == $past(mode_q))
      else $error("reserved mode accepted");
endmodule

//--- hw/scs_serial.sv
`timescale 1ns/1ps
module scs_serial (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   output logic dout,
   scs_frame_if.serial bus
);
   logic sclk_q;
   logic cs_q;
   logic [15:0] rx_q;
   logic [15:0] tx_q;
   logic [4:0] bits_q;
   logic valid_q;
   logic [15:0] frame_q;
   logic rise;
   logic fall;

   assign rise = sclk & ~sclk_q;
   assign fall = ~sclk & sclk_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sclk_q <= 1'b1;
         cs_q <= 1'b1;
      end else begin
         sclk_q <= sclk;
         cs_q <= cs_n;
      end
   end

   // ---------------------------------------------------------------
   // Receive: data sampled on rising clock edges
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_q <= 16'h0000;
         bits_q <= 5'h00;
      end else if (!cs_n && cs_q) begin
         bits_q <= 5'h00;
      end else if (!cs_n && rise && bits_q != 5'h10) begin
         rx_q <= {rx_q[14:0], din};
         bits_q <= bits_q + 5'h01;
      end
   end

   // Only complete 16-bit frames count; a busy device stays deaf
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         valid_q <= 1'b0;
         frame_q <= 16'h0000;
      end else begin
         valid_q <= cs_n && !cs_q && bits_q == 5'h10 && !bus.busy;
         if (cs_n && !cs_q) begin
            frame_q <= rx_q;
         end
      end
   end

   // ---------------------------------------------------------------
   // Transmit: first bit ready before the first rising edge
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_q <= 16'h0000;
      end else if (!cs_n && cs_q) begin
         tx_q <= bus.busy ? 16'h0000 : bus.rd_data;
      end else if (!cs_n && fall && bits_q != 5'h00) begin
         tx_q <= {tx_q[14:0], 1'b0};
      end
   end

   assign dout = tx_q[15];
   assign bus.frame_valid = valid_q;
   assign bus.frame = frame_q;
endmodule

//--- verification/scs_host_model.sv
`timescale 1ns/1ps
module scs_host_model (
   input wire logic clk,
   input wire logic dout,
   output logic cs_n,
   output logic sclk,
   output logic din
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      din = 1'b1;
   end
   // Mode 3, four clocks a half bit; released data line shows inverse
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      rx = '0;
      @(negedge clk) cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         repeat (4) @(negedge clk);
         sclk = 1'b0;
         din = tx[i];
         repeat (4) @(negedge clk);
         sclk = 1'b1;
         rx[i] = dout;
      end
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      din = ~tx[0];
      repeat (6) @(negedge clk);
   endtask
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic SYS_CLK, RESETN, SYNC_IN, SPI_CS_N, SPI_SCLK, SPI_DIN, SPI_DOUT;
   logic SYNC_OUT, SYNC_OE, DATA_READY, GYRO_LIN_G_COMP, BANDWIDTH_370;
   logic CMD_BUSY, sync_host;
   logic [47:0] GYRO_DATA, ACCEL_DATA;
   logic [95:0] DELTA_ANGLE;
   logic [15:0] rd, v;
   int num_errors = 0;
   int checked = 0;
   assign SYNC_IN = SYNC_OE ? SYNC_OUT : sync_host;
   scs_sample_clock #(.INT_PERIOD_CYC(100), .CMD_CYC(50)) u_scs_sample_clock (
      .SYS_CLK(SYS_CLK), .RESETN(RESETN), .SPI_CS_N(SPI_CS_N),
      .SPI_SCLK(SPI_SCLK), .SPI_DIN(SPI_DIN), .SPI_DOUT(SPI_DOUT),
      .SYNC_IN(SYNC_IN), .SYNC_OUT(SYNC_OUT), .SYNC_OE(SYNC_OE),
      .DATA_READY(DATA_READY), .GYRO_DATA(GYRO_DATA),
      .ACCEL_DATA(ACCEL_DATA), .DELTA_ANGLE(DELTA_ANGLE), .DELTA_VEL(),
      .BIAS_CORR(),
      .GYRO_SAMPLE(), .ACCEL_SAMPLE(), .GYRO_LIN_G_COMP(GYRO_LIN_G_COMP),
      .POC_ENABLE(), .BANDWIDTH_370(BANDWIDTH_370), .CMD_BUSY(CMD_BUSY));
   scs_host_model u_scs_host_model (.clk(SYS_CLK), .dout(SPI_DOUT),
      .cs_n(SPI_CS_N), .sclk(SPI_SCLK), .din(SPI_DIN));
   initial begin
      SYS_CLK = 1'b0;
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end
   // Host trigger: 50% duty, 100-cycle period stands for the 2000 Hz rate
   initial begin
      sync_host = 1'b0;
      forever begin
         repeat (50) @(negedge SYS_CLK);
         sync_host = ~sync_host;
      end
   end
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] r;
      u_scs_host_model.xfer({1'b1, a, d}, r);
   endtask
   // Read data comes back in the following frame
   task automatic rd16(input logic [6:0] a, output logic [15:0] r);
      logic [15:0] x;
      u_scs_host_model.xfer({1'b0, a, 8'h00}, x);
      u_scs_host_model.xfer(16'h0000, r);
   endtask
   // Low time of the ready pin: period of (d+1) ticks, k ticks per 100 cycles
   function automatic logic [15:0] gap(input logic [15:0] d, input int k);
      return 16'((d + 1) * 100 / k - scs_pkg::PULSE_CYC);
   endfunction
   function automatic logic [15:0] clamp(input logic [15:0] w);
      return (w[10:0] > 11'h7cf) ? 16'h07cf : {5'h00, w[10:0]};
   endfunction
   task automatic dr_low(output logic [15:0] n);
      repeat (2) begin
         for (int i = 0; i < 3000 && DATA_READY !== 1'b1; i++)
            @(negedge SYS_CLK);
         for (int i = 0; i < 3000 && DATA_READY === 1'b1; i++)
            @(negedge SYS_CLK);
      end
      for (n = '0; n < 3000 && DATA_READY !== 1'b1; n++) @(negedge SYS_CLK);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge SYS_CLK);
      num_errors++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'hdc99ceba));
      {RESETN, GYRO_DATA, ACCEL_DATA} = '0;
      repeat (10) @(negedge SYS_CLK);
      RESETN = 1'b1;
      chk("lin_g", 16'h0001, {15'h0, GYRO_LIN_G_COMP});
      rd16(7'h62, rd); chk("multiplier", 16'h07d0, rd);
      rd16(7'h64, rd); chk("decimation", 16'h0000, rd);
      rd16(7'h66, rd); chk("estimator", 16'h070a, rd);
      rd16(7'h68, rd); chk("command", 16'h0000, rd);
      $display("reset test done");
      wr(7'h60, 8'hd5); chk("bw370", 16'h0001, {15'h0, BANDWIDTH_370});
      wr(7'h60, 8'hd1); chk("bw370", 16'h0001, {15'h0, BANDWIDTH_370});
      wr(7'h60, 8'hcd); chk("sync_oe", 16'h0001, {15'h0, SYNC_OE});
      wr(7'h60, 8'h41); wr(7'h61, 8'h00);
      chk("lin_g", 16'h0000, {15'h0, GYRO_LIN_G_COMP});
      chk("sync_oe", 16'h0000, {15'h0, SYNC_OE});
      $display("mode test done");
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 16'h07d0 : (i == 1) ? 16'hf7cf : 16'($urandom);
         GYRO_DATA = 48'({$urandom, $urandom});
         ACCEL_DATA = 48'({$urandom, $urandom});
         wr(7'h64, 8'h00); wr(7'h65, 8'h00);
         wr(7'h64, v[7:0]); wr(7'h65, v[15:8]);
         rd16(7'h64, rd); chk("decimation", clamp(v), rd);
      end
      $display("decimation test done");
      v = 16'($urandom_range(9, 4));
      wr(7'h64, v[7:0]); wr(7'h65, 8'h00);
      dr_low(rd); chk("dr_low", gap(v, 1), rd);
      chk("delta_x", 16'((v + 1) * GYRO_DATA[15:0]),
          DELTA_ANGLE[15:0]);
      wr(7'h62, 8'h02);
      wr(7'h63, 8'h00);
      wr(7'h60, 8'h47);
      dr_low(rd);
      chk("direct_gap", gap(v, 1), rd);
      wr(7'h60, 8'h57);
      dr_low(rd);
      chk("pulse_gap", gap(v, 1), rd);
      wr(7'h60, 8'h4b);
      dr_low(rd);
      chk("scaled_gap", gap(v, 2), rd);
      $display("pacing test done");
      wr(7'h68, 8'h01); chk("busy", 16'h0001, {15'h0, CMD_BUSY});
      repeat (60) @(negedge SYS_CLK);
      chk("busy", 16'h0000, {15'h0, CMD_BUSY});
      wr(7'h69, 8'h00);
      $display("command test done");
      end_of_test();
   end
endmodule
